// ### rtl/fpes_top.sv
// Program/erase command sequencer of a serial multi-I/O flash device
// What this block does
// RULE1 - Wide-address block erase and page program always take four address bytes.
// RULE2 - Wide-address quad-data and quad-address programs always take four address bytes.
// RULE3 - In wide address mode, ordinary erase and program take four address bytes.
// RULE4 - Chip erase (two opcodes) erases everything, only with write enable latch set.
// RULE5 - Chip erase ending off a byte boundary is rejected.
// RULE6 - Chip erase starts at select rise; busy flag high, then flag and latch clear.
// RULE7 - Chip erase refused when any block protect region is set.
// RULE8 - In individual protect mode, global unlock must precede every chip erase.
// RULE9 - Single-line page program clears bits, only with write enable latch set.
// RULE10 - Data past the page end wraps to the start of the same page.
// RULE11 - More than a page sent: only the last page of bytes is kept.
// RULE12 - Fewer bytes: programmed from start address, other locations untouched.
// RULE13 - Host sends opcode, address, at least one data byte under one select.
// RULE14 - Program ending off a data byte boundary is rejected.
// RULE15 - Program starts at select rise; busy until done, then flag and latch clear.
// RULE16 - Program into a protected page is ignored.
// RULE17 - Quad-data program: opcode and address on one line, data on four.
// RULE18 - Quad-address program: address and data on four lines, latch needed.
// RULE19 - Three secure areas; area in bits 15..12, other high bits zero.
// RULE20 - Secure area erase is opcode plus address, needs the latch set.
// RULE21 - Secure erase off byte boundary skipped; else timed cycle with busy flag.
// RULE22 - A set secure area lock bit blocks that area's erase forever.
// RULE23 - While busy, new program and erase frames are ignored.
`timescale 1ns/100ps
`default_nettype none
`include "fpes_cfg.svh"
module fpes_top
	import fpes_pkg::*;
#(
	parameter int          ADDR_W           = 26,
	parameter int          FIFO_DEPTH       = 2,
	parameter int unsigned PROG_CYC         = `FPES_PROGRAM_TIME_NS / `FPES_CLK_PERIOD_NS,
	parameter int unsigned CHIP_ERASE_CYC   = `FPES_CHIP_ERASE_TIME_NS / `FPES_CLK_PERIOD_NS,
	parameter int unsigned BLOCK_ERASE_CYC  = `FPES_BLOCK_ERASE_TIME_NS / `FPES_CLK_PERIOD_NS,
	parameter int unsigned SECURE_ERASE_CYC = `FPES_SECTOR_ERASE_TIME_NS / `FPES_CLK_PERIOD_NS
)(
	input  wire logic        CORE_CLK,
	input  wire logic        ARST_N,
	input  wire logic        CS_N,
	input  wire logic        SCLK,
	input  wire logic [3:0]  IO_IN,
	input  wire logic        FOUR_WIRE_COMMAND_MODE,
	input  wire logic        WIDE_ADDRESS_MODE,
	input  wire logic [4:0]  BLOCK_PROTECT_BITS,
	input  wire logic        INDIVIDUAL_PROTECT_SELECT,
	input  wire logic [2:0]  SECURE_AREA_LOCK_BITS,
	output logic             WRITE_IN_PROGRESS_FLAG,
	output logic             WRITE_ENABLE_LATCH,
	output logic             CMD_REJECT,
	output logic             ERASE_REQ,
	output logic [1:0]       ERASE_KIND,
	output logic [31:0]      ERASE_ADDR,
	output logic             ARRAY_WR_VALID,
	input  wire logic        ARRAY_WR_READY,
	output logic [31:0]      ARRAY_WR_ADDR,
	output logic [7:0]       ARRAY_WR_DATA
);
	localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
	localparam int CW = $clog2(FIFO_DEPTH + 1);

	function automatic logic is_prog(input logic [7:0] op);
		return op == `FPES_OP_PAGE_PROG || op == `FPES_OP_PAGE_PROG_WIDE || op == `FPES_OP_QDATA_PROG ||
			op == `FPES_OP_QDATA_PROG_WIDE || op == `FPES_OP_QADDR_PROG || op == `FPES_OP_QADDR_PROG_WIDE;
	endfunction
	function automatic logic is_wide(input logic [7:0] op);
		return op == `FPES_OP_PAGE_PROG_WIDE || op == `FPES_OP_QDATA_PROG_WIDE ||
			op == `FPES_OP_QADDR_PROG_WIDE || op == `FPES_OP_BLOCK_ERASE_WIDE;
	endfunction
	function automatic logic quad_addr(input logic [7:0] op);
		return op == `FPES_OP_QADDR_PROG || op == `FPES_OP_QADDR_PROG_WIDE;
	endfunction
	function automatic logic quad_data(input logic [7:0] op);
		return quad_addr(op) || op == `FPES_OP_QDATA_PROG || op == `FPES_OP_QDATA_PROG_WIDE;
	endfunction
	function automatic logic is_block_erase(input logic [7:0] op);
		return op == `FPES_OP_BLOCK_ERASE || op == `FPES_OP_BLOCK_ERASE_WIDE;
	endfunction
	// Protected region is 2^(n-1) 64K blocks at the top, or bottom when bit 4 is set
	function automatic logic addr_protected(input logic [31:0] a, input logic [4:0] bp);
		int unsigned blk;
		int unsigned nblk;
		int unsigned size;
		blk  = int'(a[ADDR_W-1:`FPES_BLOCK_SHIFT]);
		nblk = 1 << (ADDR_W - `FPES_BLOCK_SHIFT);
		size = (bp[3:0] == 4'h0) ? 0 : (1 << (bp[3:0] - 4'h1));
		if (size >= nblk)
			return 1'b1;
		return bp[4] ? (blk < size) : (blk >= nblk - size);
	endfunction
	function automatic logic [PW-1:0] ptr_next(input logic [PW-1:0] p);
		return (int'(p) == FIFO_DEPTH - 1) ? '0 : PW'(p + 1'b1);
	endfunction

	logic [1:0] rst_sync_r;
	logic       rst_n;
	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			rst_sync_r <= 2'b00;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end
	assign rst_n = rst_sync_r[1];

	// Pins are asynchronous to the core clock; 80 ns link period gives ten samples
	logic [5:0] pin_m_r;
	logic [5:0] pin_s_r;
	logic       cs_d_r;
	logic       sck_d_r;
	always_ff @(posedge CORE_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_m_r <= `FPES_PIN_IDLE;
			pin_s_r <= `FPES_PIN_IDLE;
			cs_d_r  <= 1'b1;
			sck_d_r <= 1'b0;
		end
		else
		begin
			pin_m_r <= {CS_N, SCLK, IO_IN};
			pin_s_r <= pin_m_r;
			cs_d_r  <= pin_s_r[5];
			sck_d_r <= pin_s_r[4];
		end
	end

	logic       cs_fall;
	logic       cs_rise;
	logic       sck_rise;
	logic [3:0] io_s;
	assign io_s     = pin_s_r[3:0];
	assign cs_fall  = cs_d_r & ~pin_s_r[5];
	assign cs_rise  = ~cs_d_r & pin_s_r[5];
	assign sck_rise = pin_s_r[4] & ~sck_d_r & ~pin_s_r[5];

	fpes_rx_t    state_r;
	logic [7:0]  op_r;
	logic [7:0]  sh_r;
	logic [3:0]  bit_r;
	logic [2:0]  abytes_r;
	logic [31:0] addr_r;
	logic [7:0]  ptr_r;
	logic        got_data_r;
	logic        wip_r;
	logic        wel_r;
	logic        unlock_r;
	logic [7:0]  page_mem [0:255];
	logic [255:0] page_vld_r;

	logic        quad;
	logic [7:0]  sh_nxt;
	logic [3:0]  bit_nxt;
	logic        byte_done;
	assign quad      = FOUR_WIRE_COMMAND_MODE || (state_r == ST_ADDR && quad_addr(op_r)) ||
		(state_r == ST_DATA && quad_data(op_r)); // RULE17 RULE18
	assign sh_nxt    = quad ? {sh_r[3:0], io_s} : {sh_r[6:0], io_s[0]};
	assign bit_nxt   = bit_r + (quad ? `FPES_STEP_QUAD : `FPES_STEP_SINGLE);
	assign byte_done = sck_rise && bit_nxt == `FPES_BYTE_BITS;

	always_ff @(posedge CORE_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r    <= ST_IDLE;
			op_r       <= 8'h00;
			sh_r       <= 8'h00;
			bit_r      <= 4'h0;
			abytes_r   <= 3'h0;
			addr_r     <= 32'h0;
			ptr_r      <= 8'h00;
			got_data_r <= 1'b0;
		end
		else if (cs_fall)
		begin
			state_r    <= wip_r ? ST_SKIP : ST_CMD; // RULE23
			bit_r      <= 4'h0;
			addr_r     <= 32'h0;
			got_data_r <= 1'b0;
		end
		else if (cs_rise)
			state_r <= ST_IDLE;
		else if (sck_rise && state_r != ST_IDLE && state_r != ST_SKIP)
		begin
			sh_r  <= sh_nxt;
			bit_r <= byte_done ? 4'h0 : bit_nxt;
			if (state_r == ST_TAIL)
				state_r <= ST_SKIP; // RULE5 RULE21
			else if (byte_done)
			begin
				unique case (state_r)
					ST_CMD:
					begin
						op_r <= sh_nxt;
						abytes_r <= (is_wide(sh_nxt) || WIDE_ADDRESS_MODE) ?
							`FPES_ADDR_BYTES_WIDE : `FPES_ADDR_BYTES_NARROW; // RULE1 RULE2 RULE3 RULE20
						if (is_prog(sh_nxt) || is_block_erase(sh_nxt) || sh_nxt == `FPES_OP_SECURE_ERASE)
							state_r <= ST_ADDR;
						else if (sh_nxt == `FPES_OP_WRITE_EN || sh_nxt == `FPES_OP_GLOBAL_UNLOCK ||
							sh_nxt == `FPES_OP_CHIP_ERASE_A || sh_nxt == `FPES_OP_CHIP_ERASE_B)
							state_r <= ST_TAIL;
						else
							state_r <= ST_SKIP;
					end
					ST_ADDR:
					begin
						addr_r   <= {addr_r[23:0], sh_nxt};
						abytes_r <= abytes_r - 3'h1;
						ptr_r    <= sh_nxt; // RULE12
						if (abytes_r == 3'h1)
							state_r <= is_prog(op_r) ? ST_DATA : ST_TAIL; // RULE13
					end
					ST_DATA:
					begin
						ptr_r      <= ptr_r + 8'h01; // RULE10
						got_data_r <= 1'b1;
					end
					default:
						state_r <= ST_SKIP;
				endcase
			end
		end
	end

	// Later bytes simply overwrite earlier ones, so only the last page survives
	always_ff @(posedge CORE_CLK)
	begin
		if (byte_done && state_r == ST_DATA && !cs_rise && !cs_fall)
			page_mem[ptr_r] <= sh_nxt; // RULE11
	end
	always_ff @(posedge CORE_CLK or negedge rst_n)
	begin
		if (!rst_n)
			page_vld_r <= '0;
		else if (byte_done && state_r == ST_ADDR && abytes_r == 3'h1 && !cs_rise && !cs_fall)
			page_vld_r <= '0;
		else if (byte_done && state_r == ST_DATA && !cs_rise && !cs_fall)
			page_vld_r[ptr_r] <= 1'b1; // RULE11 RULE12
	end

	logic ok_tail;
	logic is_chip;
	logic do_write_enable_command;
	logic do_unlock;
	logic ce_ok;
	logic be_ok;
	logic sa_ok;
	logic pg_ok;
	logic accept;
	logic [3:0] area;
	logic sa_addr_ok;
	assign area       = addr_r[15:12];
	assign sa_addr_ok = addr_r[31:16] == 16'h0 && addr_r[11:10] == 2'b00 &&
		area >= `FPES_AREA_FIRST && area <= `FPES_AREA_LAST; // RULE19
	assign ok_tail    = cs_rise && !wip_r && state_r == ST_TAIL && bit_r == 4'h0; // RULE5
	assign is_chip    = op_r == `FPES_OP_CHIP_ERASE_A || op_r == `FPES_OP_CHIP_ERASE_B;
	assign do_write_enable_command    = ok_tail && op_r == `FPES_OP_WRITE_EN;
	assign do_unlock  = ok_tail && op_r == `FPES_OP_GLOBAL_UNLOCK;
	assign ce_ok      = ok_tail && is_chip && wel_r && BLOCK_PROTECT_BITS[3:0] == 4'h0 &&
		(!INDIVIDUAL_PROTECT_SELECT || unlock_r); // RULE4 RULE7 RULE8
	assign be_ok      = ok_tail && is_block_erase(op_r) && wel_r && !addr_protected(addr_r, BLOCK_PROTECT_BITS);
	assign sa_ok      = ok_tail && op_r == `FPES_OP_SECURE_ERASE && wel_r && sa_addr_ok &&
		!SECURE_AREA_LOCK_BITS[area[1:0] - 2'b01]; // RULE20 RULE22
	assign pg_ok      = cs_rise && !wip_r && state_r == ST_DATA && bit_r == 4'h0 && got_data_r &&
		wel_r && !addr_protected(addr_r, BLOCK_PROTECT_BITS); // RULE9 RULE14 RULE16 RULE18
	assign accept     = ce_ok || be_ok || sa_ok || pg_ok;

	logic [31:0] timer_r;
	logic        prog_job_r;
	logic [8:0]  drain_r;
	logic [CW-1:0] fifo_cnt_r;
	logic        busy_done;
	assign busy_done = wip_r && timer_r == 32'h0 && (!prog_job_r || drain_r == `FPES_PAGE_BYTES) &&
		fifo_cnt_r == '0;

	always_ff @(posedge CORE_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wip_r      <= 1'b0;
			wel_r      <= 1'b0;
			timer_r    <= 32'h0;
			prog_job_r <= 1'b0;
			CMD_REJECT <= 1'b0;
		end
		else
		begin
			CMD_REJECT <= cs_rise && !wip_r && state_r != ST_IDLE && !accept && !do_write_enable_command && !do_unlock;
			if (accept)
			begin
				wip_r      <= 1'b1; // RULE6 RULE15 RULE21
				prog_job_r <= pg_ok;
				timer_r    <= pg_ok ? PROG_CYC - 1 : ce_ok ? CHIP_ERASE_CYC - 1 :
					be_ok ? BLOCK_ERASE_CYC - 1 : SECURE_ERASE_CYC - 1;
			end
			else if (busy_done)
			begin
				wip_r <= 1'b0; // RULE6 RULE15
				wel_r <= 1'b0;
			end
			else if (timer_r != 32'h0)
				timer_r <= timer_r - 32'h1;
			if (do_write_enable_command)
				wel_r <= 1'b1;
		end
	end

	always_ff @(posedge CORE_CLK or negedge rst_n)
	begin
		if (!rst_n)
			unlock_r <= 1'b0;
		else if (do_unlock)
			unlock_r <= 1'b1; // RULE8
		else if (ce_ok)
			unlock_r <= 1'b0;
	end

	always_ff @(posedge CORE_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ERASE_REQ  <= 1'b0;
			ERASE_KIND <= ERS_CHIP;
			ERASE_ADDR <= 32'h0;
		end
		else
		begin
			ERASE_REQ <= ce_ok || be_ok || sa_ok;
			if (ce_ok || be_ok || sa_ok)
			begin
				ERASE_KIND <= ce_ok ? ERS_CHIP : be_ok ? ERS_BLOCK : ERS_SECURE;
				ERASE_ADDR <= ce_ok ? 32'h0 : addr_r; // RULE4
			end
		end
	end

	// Drain walks the whole page, pushing only loaded bytes; a stalled array stalls it
	logic [39:0]   fifo_mem [0:FIFO_DEPTH-1];
	logic [PW-1:0] wr_ptr_r;
	logic [PW-1:0] rd_ptr_r;
	logic          in_ready;
	logic          in_valid;
	logic          pop;
	logic          push;
	logic [31:0]   base_addr;
	assign base_addr = {addr_r[31:8], 8'h00};
	assign in_ready  = int'(fifo_cnt_r) < FIFO_DEPTH;
	assign in_valid  = prog_job_r && wip_r && !drain_r[8] && page_vld_r[drain_r[7:0]];
	assign push      = in_valid && in_ready;
	assign pop       = ARRAY_WR_VALID && ARRAY_WR_READY;

	always_ff @(posedge CORE_CLK or negedge rst_n)
	begin
		if (!rst_n)
			drain_r <= 9'h0;
		else if (pg_ok)
			drain_r <= 9'h0;
		else if (prog_job_r && wip_r && !drain_r[8] && (push || !page_vld_r[drain_r[7:0]]))
			drain_r <= drain_r + 9'h1;
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (push)
			fifo_mem[wr_ptr_r] <= {base_addr | {24'h0, drain_r[7:0]}, page_mem[drain_r[7:0]]};
	end
	always_ff @(posedge CORE_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr_r   <= '0;
			rd_ptr_r   <= '0;
			fifo_cnt_r <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_r <= ptr_next(wr_ptr_r);
			if (pop)
				rd_ptr_r <= ptr_next(rd_ptr_r);
			fifo_cnt_r <= fifo_cnt_r + CW'(push) - CW'(pop);
		end
	end
	assign ARRAY_WR_VALID = fifo_cnt_r != '0;
	assign ARRAY_WR_ADDR  = fifo_mem[rd_ptr_r][39:8];
	assign ARRAY_WR_DATA  = fifo_mem[rd_ptr_r][7:0];
	assign WRITE_IN_PROGRESS_FLAG = wip_r;
	assign WRITE_ENABLE_LATCH     = wel_r;

	AST_START_NEEDS_LATCH: assert property (@(posedge CORE_CLK) disable iff (!rst_n) // RULE4
		$rose(wip_r) |-> $past(wel_r))
		else $error("busy started without write enable latch");
	AST_DONE_CLEARS_LATCH: assert property (@(posedge CORE_CLK) disable iff (!rst_n) // RULE6
		$fell(wip_r) |-> !wel_r)
		else $error("latch still set after cycle end");
	AST_PROTECTED_CHIP: assert property (@(posedge CORE_CLK) disable iff (!rst_n) // RULE7
		(ok_tail && is_chip && BLOCK_PROTECT_BITS[3:0] != 4'h0) |=> !wip_r && !ERASE_REQ)
		else $error("chip erase ran while protected");
	AST_OFF_BOUNDARY: assert property (@(posedge CORE_CLK) disable iff (!rst_n) // RULE14
		(cs_rise && !wip_r && bit_r != 4'h0) |=> !wip_r)
		else $error("frame ended mid-byte was executed");
	AST_BUSY_FRAME_SKIP: assert property (@(posedge CORE_CLK) disable iff (!rst_n) // RULE23
		(cs_fall && wip_r) |=> state_r == ST_SKIP)
		else $error("frame decoded while busy");
	AST_PAGE_WRAP: assert property (@(posedge CORE_CLK) disable iff (!rst_n) // RULE10
		(byte_done && state_r == ST_DATA && ptr_r == `FPES_PAGE_LAST && !cs_rise && !cs_fall) |=> ptr_r == 8'h00)
		else $error("page pointer did not wrap");
	AST_ERASE_PULSE: assert property (@(posedge CORE_CLK) disable iff (!rst_n) // RULE21
		(ce_ok || be_ok || sa_ok) |=> ERASE_REQ && wip_r ##1 !ERASE_REQ)
		else $error("erase request not a single pulse");
	AST_LOCKED_AREA: assert property (@(posedge CORE_CLK) disable iff (!rst_n) // RULE22
		(ok_tail && op_r == `FPES_OP_SECURE_ERASE && sa_addr_ok && SECURE_AREA_LOCK_BITS[area[1:0] - 2'b01]) |=>
		!ERASE_REQ && !wip_r)
		else $error("locked secure area erased");
	AST_WIDE_ADDR: assert property (@(posedge CORE_CLK) disable iff (!rst_n) // RULE1
		(byte_done && state_r == ST_CMD && is_wide(sh_nxt) && !cs_rise && !cs_fall) |=>
		abytes_r == `FPES_ADDR_BYTES_WIDE)
		else $error("wide opcode did not take four address bytes");
endmodule
`default_nettype wire

// ### rtl/fpes_cfg.svh
// Opcodes, field limits and timing constants of the program/erase sequencer
`ifndef FPES_CFG_SVH
`define FPES_CFG_SVH
`define FPES_OP_WRITE_EN         8'h06
`define FPES_OP_GLOBAL_UNLOCK    8'h98
`define FPES_OP_CHIP_ERASE_A     8'h60
`define FPES_OP_CHIP_ERASE_B     8'hC7
`define FPES_OP_PAGE_PROG        8'h02
`define FPES_OP_PAGE_PROG_WIDE   8'h12
`define FPES_OP_QDATA_PROG       8'h32
`define FPES_OP_QDATA_PROG_WIDE  8'h34
`define FPES_OP_QADDR_PROG       8'hC2
`define FPES_OP_QADDR_PROG_WIDE  8'h3E
`define FPES_OP_BLOCK_ERASE      8'hD8
`define FPES_OP_BLOCK_ERASE_WIDE 8'hDC
`define FPES_OP_SECURE_ERASE     8'h44
`define FPES_ADDR_BYTES_NARROW   3'h3
`define FPES_ADDR_BYTES_WIDE     3'h4
`define FPES_STEP_SINGLE         4'h1
`define FPES_STEP_QUAD           4'h4
`define FPES_BYTE_BITS           4'h8
`define FPES_PAGE_LAST           8'hFF
`define FPES_PAGE_BYTES          9'h100
`define FPES_BLOCK_SHIFT         16
`define FPES_AREA_FIRST          4'h1
`define FPES_AREA_LAST           4'h3
`define FPES_PIN_IDLE            6'h20
`define FPES_CLK_PERIOD_NS       8
`define FPES_PROGRAM_TIME_NS     400000
`define FPES_CHIP_ERASE_TIME_NS  2000000
`define FPES_BLOCK_ERASE_TIME_NS 200000
`define FPES_SECTOR_ERASE_TIME_NS 100000
`endif

// ### rtl/fpes_pkg.sv
// Types shared by the program/erase sequencer
package fpes_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_CMD  = 3'b001,
		ST_ADDR = 3'b010,
		ST_DATA = 3'b011,
		ST_TAIL = 3'b100,
		ST_SKIP = 3'b101
	} fpes_rx_t;
	typedef enum logic [1:0] {
		ERS_CHIP   = 2'b00,
		ERS_BLOCK  = 2'b01,
		ERS_SECURE = 2'b10
	} fpes_erase_t;
endpackage

// ### verification/fpes_host_model.sv
// Host controller model that frames commands on the chip select, link clock and I/O lines
`timescale 1ns/100ps
`default_nettype none
module fpes_host_model (
	input  wire logic       clk,
	output logic            cs_n,
	output logic            sclk,
	output logic [3:0]      io
);
	logic [7:0] mem [0:599];

	initial
	begin
		cs_n = 1'b1;
		sclk = 1'b0;
		io   = 4'h5;
	end

	// A high half of 5 core cycles and a low half of 6 keep the link clock slower than 80 ns
	task automatic edge_out(input logic [3:0] v);
		@(posedge clk);
		io <= v;
		repeat (5) @(posedge clk);
		sclk <= 1'b1;
		repeat (5) @(posedge clk);
		sclk <= 1'b0;
	endtask

	// Bytes from index qf on go four lines wide, high nibble first
	task automatic frame(input int n, input int qf, input int extra);
		repeat (8) @(posedge clk);
		cs_n <= 1'b0;
		for (int i = 0; i < n; i++)
			if (i >= qf)
			begin
				edge_out(mem[i][7:4]);
				edge_out(mem[i][3:0]);
			end
			else
				for (int b = 7; b >= 0; b--)
					edge_out({~io[3:1], mem[i][b]});
		repeat (extra) edge_out(~io);
		repeat (5) @(posedge clk);
		cs_n <= 1'b1;
		io   <= ~io;
	endtask
endmodule
`default_nettype wire

// ### verification/test_fpes_top.sv
// Self-checking bench for the program/erase sequencer
`timescale 1ns/100ps
`default_nettype none
module test_fpes_top;
	localparam int PROG_CYC = 40;
	localparam int CHIP_CYC = 2000;
	localparam int BLK_CYC  = 30;
	localparam int SEC_CYC  = 20;
	logic        core_clk = 1'b0;
	logic        arst_n   = 1'b0;
	wire logic   cs_n;
	wire logic   sclk;
	wire logic [3:0] io;
	logic        wide     = 1'b0;
	logic        fourw    = 1'b0;
	logic [4:0]  prot     = 5'h00;
	logic        ips      = 1'b0;
	logic [2:0]  lock     = 3'h0;
	logic        stall    = 1'b0;
	logic        ready    = 1'b0;
	logic [31:0] rnd      = 32'hB559197F;
	logic [31:0] rd       = 32'hB559197F;
	wire logic   write_in_progress_flag, write_enable_latch, rej, ereq, valid;
	wire logic [1:0] ekind;
	wire logic [31:0] eaddr, waddr;
	wire logic [7:0] wdata;
	logic [7:0]  seen [0:255];
	logic [7:0]  eimg [0:255];
	logic [23:0] base_r;
	int          nwr, n_errors, n_compared, cyc;

	fpes_top #(.PROG_CYC(PROG_CYC), .CHIP_ERASE_CYC(CHIP_CYC), .BLOCK_ERASE_CYC(BLK_CYC),
		.SECURE_ERASE_CYC(SEC_CYC)) u_dut (
		.CORE_CLK                  (core_clk),
		.ARST_N                    (arst_n),
		.CS_N                      (cs_n),
		.SCLK                      (sclk),
		.IO_IN                     (io),
		.FOUR_WIRE_COMMAND_MODE    (fourw),
		.WIDE_ADDRESS_MODE         (wide),
		.BLOCK_PROTECT_BITS        (prot),
		.INDIVIDUAL_PROTECT_SELECT (ips),
		.SECURE_AREA_LOCK_BITS     (lock),
		.WRITE_IN_PROGRESS_FLAG    (write_in_progress_flag),
		.WRITE_ENABLE_LATCH        (write_enable_latch),
		.CMD_REJECT                (rej),
		.ERASE_REQ                 (ereq),
		.ERASE_KIND                (ekind),
		.ERASE_ADDR                (eaddr),
		.ARRAY_WR_VALID            (valid),
		.ARRAY_WR_READY            (ready),
		.ARRAY_WR_ADDR             (waddr),
		.ARRAY_WR_DATA             (wdata)
	);
	fpes_host_model u_host (.clk(core_clk), .cs_n(cs_n), .sclk(sclk), .io(io));

	always #4 core_clk = ~core_clk;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic int cyc_of(input logic [7:0] op);
		case (op)
			8'h60, 8'hC7: return CHIP_CYC - 2;
			8'hD8, 8'hDC: return BLK_CYC - 2;
			8'h44:        return SEC_CYC - 2;
			default:      return PROG_CYC - 2;
		endcase
	endfunction
	function automatic logic [1:0] kind_of(input logic [7:0] op);
		return (op == 8'h60 || op == 8'hC7) ? 2'h0 : (op == 8'h44) ? 2'h2 : 2'h1;
	endfunction
	function automatic int wr_count(input int nd);
		return (nd > 256) ? 256 : nd;
	endfunction

	// Random stalls on the array side exercise the two-entry buffer
	always @(posedge core_clk)
	begin
		rnd   <= lfsr(rnd);
		ready <= !stall && (rnd[0] | rnd[5]);
		cyc   <= cyc + 1;
		if (cyc == 90000)
		begin
			n_errors++;
			final_report();
		end
	end

	always @(posedge core_clk)
		if (valid === 1'b1 && ready === 1'b1)
		begin
			seen[waddr[7:0]] = wdata;
			base_r = waddr[31:8];
			nwr = nwr + 1;
		end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] %0t: saw %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic wdone(input int lo);
		int n;
		n = 0;
		while (write_in_progress_flag === 1'b1 && n < 20000)
		begin
			@(negedge core_clk);
			n++;
		end
		chk(n >= lo, 1);
		@(negedge core_clk);
		chk({write_in_progress_flag, write_enable_latch}, 0);
	endtask

	task automatic pchk(input logic [31:0] a, input int na, input int nd);
		chk(nwr, wr_count(nd));
		for (int i = 0; i < nd; i++)
			eimg[(a[7:0] + i) % 256] = u_host.mem[1 + na + i];
		for (int i = 0; i < wr_count(nd); i++)
			chk(seen[(a[7:0] + i) % 256], eimg[(a[7:0] + i) % 256]);
		chk(base_r, a[31:8]);
	endtask

	// Outcome seen: 0 nothing, 1 refused, 2 erase started, 3 program started
	task automatic run(input logic [7:0] op, input logic [31:0] a, input int na, input int nd, input int qf,
		input int ex, input logic we, input logic [1:0] res, input logic w);
		logic [1:0] got;
		logic       w0;
		if (na < 4)
			a[31:24] = 8'h00;
		if (we)
		begin
			u_host.mem[0] = 8'h06;
			u_host.frame(1, 9, 0);
			repeat (8) @(negedge core_clk);
			chk(write_enable_latch, 1);
		end
		u_host.mem[0] = op;
		for (int i = 0; i < na; i++)
			u_host.mem[1 + i] = 8'(a >> (8 * (na - 1 - i)));
		for (int i = 0; i < nd; i++)
		begin
			rd = lfsr(rd);
			u_host.mem[1 + na + i] = rd[7:0];
		end
		nwr = 0;
		w0 = write_in_progress_flag;
		u_host.frame(1 + na + nd, qf, ex);
		got = 2'h0;
		for (int k = 0; k < 30 && got == 2'h0; k++)
		begin
			@(negedge core_clk);
			if (rej === 1'b1)
				got = 2'h1;
			else if (write_in_progress_flag === 1'b1 && w0 !== 1'b1)
				got = (ereq === 1'b1) ? 2'h2 : 2'h3;
		end
		chk(got, res);
		if (got == 2'h2)
		begin
			chk(ekind, kind_of(op));
			chk(eaddr, a);
		end
		if (got >= 2'h2 && w)
		begin
			wdone(cyc_of(op));
			if (got == 2'h3)
				pchk(a, na, nd);
		end
	endtask

	task automatic final_report;
		$display("compared %0d, errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial
	begin
		repeat (2) @(posedge core_clk);
		arst_n <= 1'b1;
		repeat (10) @(posedge core_clk);
		run(8'h02, 32'h00001210, 3, 2, 99, 0, 1'b0, 2'h1, 1'b1);
		stall = 1'b1;
		run(8'h02, 32'h000012FE, 3, 4, 99, 0, 1'b1, 2'h3, 1'b0);
		repeat (30) @(negedge core_clk);
		chk({valid, write_in_progress_flag}, 2'h3);
		stall = 1'b0;
		wdone(PROG_CYC - 31);
		pchk(32'h000012FE, 3, 4);
		for (int i = 0; i < 6; i++)
		begin
			rd = lfsr(rd);
			run(8'(48'h02123234C23E >> (40 - 8 * i)), {6'h00, rd[25:0]}, 3 + i % 2, 1 + rd[31:27],
				(i < 2) ? 99 : (i < 4) ? 4 + i % 2 : 1, 0, 1'b1, 2'h3, 1'b1);
		end
		fourw <= 1'b1;
		u_host.mem[0] = 8'h06;
		u_host.frame(1, 0, 0);
		run(8'h02, 32'h00004480, 3, 2, 0, 0, 1'b0, 2'h3, 1'b1);
		fourw <= 1'b0;
		wide <= 1'b1;
		run(8'h02, 32'h00345600, 4, 3, 99, 0, 1'b1, 2'h3, 1'b1);
		run(8'hD8, 32'h00340000, 4, 0, 99, 0, 1'b1, 2'h2, 1'b1);
		wide <= 1'b0;
		run(8'hDC, 32'h00120000, 4, 0, 99, 0, 1'b1, 2'h2, 1'b1);
		run(8'h32, 32'h00007710, 3, 258, 4, 0, 1'b1, 2'h3, 1'b1);
		run(8'h02, 32'h00000100, 3, 2, 99, 3, 1'b1, 2'h1, 1'b1);
		run(8'h02, 32'h00000100, 3, 0, 99, 0, 1'b1, 2'h1, 1'b1);
		prot <= 5'h01;
		run(8'h12, 32'h03FF0100, 4, 2, 99, 0, 1'b1, 2'h1, 1'b1);
		run(8'h60, 32'h00000000, 0, 0, 99, 0, 1'b1, 2'h1, 1'b1);
		prot <= 5'h00;
		run(8'hC7, 32'h00000000, 0, 0, 99, 0, 1'b1, 2'h2, 1'b1);
		run(8'hC7, 32'h00000000, 0, 0, 99, 4, 1'b1, 2'h1, 1'b1);
		ips <= 1'b1;
		run(8'h60, 32'h00000000, 0, 0, 99, 0, 1'b1, 2'h1, 1'b1);
		u_host.mem[0] = 8'h98;
		u_host.frame(1, 9, 0);
		run(8'h60, 32'h00000000, 0, 0, 99, 0, 1'b1, 2'h2, 1'b0);
		run(8'h02, 32'h00000200, 3, 1, 99, 0, 1'b0, 2'h0, 1'b0);
		wdone(CHIP_CYC - 500);
		ips <= 1'b0;
		run(8'h44, 32'h00002000, 3, 0, 99, 0, 1'b1, 2'h2, 1'b1);
		run(8'h44, 32'h00001400, 3, 0, 99, 0, 1'b1, 2'h1, 1'b1);
		run(8'h44, 32'h00003000, 3, 0, 99, 5, 1'b1, 2'h1, 1'b1);
		lock <= 3'h2;
		run(8'h44, 32'h00002000, 3, 0, 99, 0, 1'b1, 2'h1, 1'b1);
		run(8'h44, 32'h00003000, 3, 0, 99, 0, 1'b1, 2'h2, 1'b1);
		final_report();
	end
endmodule
`default_nettype wire
